/* logic/mpb_debounce.sv */
// Synchroniser and counter debouncer for one carrier input
`timescale 1ns/10ps
module mpb_debounce
  import mpb_pkg::*;
#(
  // Stable cycles needed before a new level is taken
  parameter int unsigned DB_CYC = MIN_PULSE_CYC
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Raw pin and filtered level
  input  wire logic pin_in,
  output logic      level_r
);

  logic            meta_r;
  logic            sync_r;
  logic [DB_W-1:0] cnt_r;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
    end
  end

  // Accept level after stable minimum width
  // Counter restarts on any bounce, so glitches never pass
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_r   <= '0;
      level_r <= 1'b1;
    end else if (sync_r == level_r) begin
      cnt_r <= '0;
    end else if (cnt_r == DB_W'(DB_CYC - 1)) begin
      cnt_r   <= '0;
      level_r <= sync_r;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // Filtered level only moves to the value the synchronised input held
  a_db_stable: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $changed(level_r) |-> $past(sync_r) == level_r)
    else $error("Debounced level took a value not seen on input");

  // A short window count would let bounces through
  a_db_window: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    $changed(level_r) |-> $past(cnt_r) == DB_W'(DB_CYC - 1))
    else $error("Debounced level moved before the window ended");

endmodule // mpb_debounce

/* logic/mpb_manager.sv */
// Power, reset, sleep and boot source manager toward the carrier
`timescale 1ns/10ps
module mpb_manager
  import mpb_pkg::*;
#(
  // Debounce window in clock cycles
  parameter int unsigned DB_CYC = MIN_PULSE_CYC
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Carrier open-drain inputs
  input  wire logic             supply_fault_n,
  input  wire logic             reset_request_n,
  input  wire logic             power_button_n,
  input  wire logic             sleep_request_n,
  input  wire logic             lid_closed_n,
  input  wire logic             battery_low_n,
  input  wire logic             charging_n,
  input  wire logic             charger_input_present_n,
  input  wire logic             test_request_n,
  input  wire logic             pm_bus_alert_n,
  // Sleep state signals from the system
  input  wire logic             suspend_to_disk_state_n,
  input  wire logic             suspend_to_ram_state_n,
  // Boot straps
  input  wire logic             boot_source_strap0_n,
  input  wire logic             boot_source_strap1_n,
  input  wire logic             boot_source_strap2_n,
  // Reset-time strap pins: input, output value, output enable
  input  wire logic [7:0]       strap_pins_in,
  input  wire logic [7:0]       strap_pins_func,
  output logic      [7:0]       strap_pins_out,
  output logic      [7:0]       strap_pins_oe,
  // Multiplexed pin configuration
  input  wire logic [6:0]       gpio_mode_req,
  input  wire logic             gpio_mode_write,
  // Outputs toward carrier and system
  output logic                  carrier_power_enable,
  output logic                  carrier_standby_n,
  output logic                  reset_out_n,
  output logic                  supply_enable,
  output logic                  module_reset_req,
  output logic                  power_button_press,
  output logic                  sleep_request,
  output logic                  lid_closed,
  output logic                  battery_low,
  output logic                  charging,
  output logic                  charger_present,
  output logic                  test_mode,
  output logic                  pm_bus_irq,
  output mpb_boot_t             boot_source,
  output mpb_fw_t               firmware_source,
  output logic      [7:0]       strap_config,
  output logic      [6:0]       alt_function_sel
);

  logic [NUM_IN-1:0] raw_in;
  logic [NUM_IN-1:0] db_level;
  logic              btn_prev_r;
  logic              st_in_rst_r;
  logic [2:0]        lvl_meta_r;
  logic [2:0]        lvl_sync_r;

  // Bundle the inputs that need a minimum pulse width
  assign raw_in[IN_RESET]  = reset_request_n;
  assign raw_in[IN_BUTTON] = power_button_n;
  assign raw_in[IN_SLEEP]  = sleep_request_n;
  assign raw_in[IN_LID]    = lid_closed_n;

  // Debounce the 16 ms carrier inputs
  for (genvar i = 0; i < NUM_IN; i++) begin : g_db
    mpb_debounce #(.DB_CYC (DB_CYC)) u_db (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .pin_in  (raw_in[i]),
      .level_r (db_level[i])
    );
  end

  // Level inputs that need no width: two flops
  // First stage feeds only the second, never logic
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lvl_meta_r <= 3'h7;
      lvl_sync_r <= 3'h7;
    end else begin
      lvl_meta_r <= {supply_fault_n, test_request_n, pm_bus_alert_n};
      lvl_sync_r <= lvl_meta_r;
    end
  end

  // Supplies off while supply fault is held
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      supply_enable <= RST_POWER_EN;
    end else begin
      supply_enable <= lvl_sync_r[2];
    end
  end

  // Power enable follows disk suspend state
  // Forced off during supply fault so carrier rails stay down
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      carrier_power_enable <= RST_POWER_EN;
    end else begin
      carrier_power_enable <= suspend_to_disk_state_n & lvl_sync_r[2];
    end
  end

  // Standby output follows RAM suspend state
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      carrier_standby_n <= RST_STANDBY_N;
    end else begin
      carrier_standby_n <= suspend_to_ram_state_n;
    end
  end

  // Valid reset pulse requests a module reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      module_reset_req <= 1'b0;
    end else begin
      module_reset_req <= ~db_level[IN_RESET];
    end
  end

  // General reset output, low in reset or request
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reset_out_n <= RST_RESET_N;
    end else begin
      reset_out_n <= db_level[IN_RESET];
    end
  end

  // One-cycle pulse per accepted button press
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      btn_prev_r         <= 1'b1;
      power_button_press <= 1'b0;
    end else begin
      btn_prev_r         <= db_level[IN_BUTTON];
      power_button_press <= btn_prev_r & ~db_level[IN_BUTTON];
    end
  end

  // Sleep and lid levels after debounce
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sleep_request <= 1'b0;
      lid_closed    <= 1'b0;
    end else begin
      sleep_request <= ~db_level[IN_SLEEP];
      lid_closed    <= ~db_level[IN_LID];
    end
  end

  // Battery low, with charger status passed through
  // Charger lines are status only, no debounce is needed
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      battery_low     <= 1'b0;
      charging        <= 1'b0;
      charger_present <= 1'b0;
    end else begin
      battery_low     <= ~battery_low_n;
      charging        <= ~charging_n;
      charger_present <= ~charger_input_present_n;
    end
  end

  // Test mode and bus interrupt request
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      test_mode  <= 1'b0;
      pm_bus_irq <= 1'b0;
    end else begin
      test_mode  <= ~lvl_sync_r[1];
      pm_bus_irq <= ~lvl_sync_r[0];
    end
  end

  // Read boot straps; code maps to source
  // Carrier firmware only for carrier SPI
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      boot_source     <= MPB_BOOT_MODULE_SPI;
      firmware_source <= MPB_FW_MODULE;
    end else begin
      boot_source <= mpb_boot_t'({boot_source_strap2_n,
                                  boot_source_strap1_n,
                                  boot_source_strap0_n});
      case ({boot_source_strap2_n, boot_source_strap1_n,
             boot_source_strap0_n})
        MPB_BOOT_CARRIER_SPI: firmware_source <= MPB_FW_CARRIER;
        default:              firmware_source <= MPB_FW_MODULE;
      endcase
    end
  end

  // Strap pins are inputs while reset is held
  // Value is caught on the first edge after release
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_in_rst_r <= 1'b1;
    end else begin
      st_in_rst_r <= 1'b0;
    end
  end

  // Capture strap levels, then drive as outputs
  // Carrier loads here would corrupt the sample
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      strap_config   <= 8'h00;
      strap_pins_oe  <= 8'h00;
      strap_pins_out <= 8'h00;
    end else begin
      if (st_in_rst_r) begin
        strap_config <= strap_pins_in;
      end
      strap_pins_oe  <= 8'hff;
      strap_pins_out <= strap_pins_func;
    end
  end

  // Multiplexed pins start on alternate functions
  // A set bit selects the alternate use, clear gives GPIO
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      alt_function_sel <= RST_ALT_SEL;
    end else if (gpio_mode_write) begin
      alt_function_sel <= ~gpio_mode_req;
    end
  end

  // Supplies drop the cycle after the synchronised fault
  a_fault_supply_off: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    !lvl_sync_r[2] |=> !supply_enable && !carrier_power_enable)
    else $error("Supplies enabled during supply fault");

  // Carrier rails stay off in the disk suspend state
  a_power_disk: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    !suspend_to_disk_state_n |=> !carrier_power_enable)
    else $error("Carrier power on in disk suspend state");

  a_standby_follow: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    !suspend_to_ram_state_n |=> !carrier_standby_n)
    else $error("Standby output not low in standby state");

  // Filtered levels reach the outputs one cycle later
  // The first cycle after reset is skipped, outputs hold reset values
  a_reset_req_follow: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    $past(rst_n) |-> module_reset_req == !$past(db_level[IN_RESET]))
    else $error("Reset request level mismatch");

  a_reset_out_pair: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    module_reset_req |-> !reset_out_n)
    else $error("Reset output high while reset requested");

  a_press_edge: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    $fell(db_level[IN_BUTTON]) |=> power_button_press)
    else $error("Accepted press gave no pulse");

  a_press_single: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    power_button_press |=> !power_button_press)
    else $error("Button press pulse longer than one cycle");

  a_sleep_follow: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    $past(rst_n) |-> sleep_request == !$past(db_level[IN_SLEEP]))
    else $error("Sleep request level mismatch");

  a_lid_follow: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    $past(rst_n) |-> lid_closed == !$past(db_level[IN_LID]))
    else $error("Lid closed level mismatch");

  a_battery_follow: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    $past(rst_n) |-> battery_low == !$past(battery_low_n))
    else $error("Battery low level mismatch");

  a_test_follow: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    $past(rst_n) |-> test_mode == !$past(lvl_sync_r[1]))
    else $error("Test mode level mismatch");

  a_fw_carrier_spi: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    (firmware_source == MPB_FW_CARRIER) ==
    (boot_source == MPB_BOOT_CARRIER_SPI))
    else $error("Firmware source does not match straps");

  a_strap_hold: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    !st_in_rst_r |=> $stable(strap_config))
    else $error("Strap config changed after reset");

  a_alt_default: assert property (@(posedge clk_sys)
    $rose(rst_n) |-> alt_function_sel == RST_ALT_SEL)
    else $error("Pins not in alternate function after reset");

  a_irq_follow: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    pm_bus_irq == !$past(lvl_sync_r[0]))
    else $error("Bus alert interrupt mismatch");

endmodule // mpb_manager

/* logic/mpb_pkg.sv */
// Package of constants for the module power and boot manager
package mpb_pkg;

  // Clock period and minimum detected pulse width
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned MIN_PULSE_MS   = 16;
  localparam int unsigned MIN_PULSE_CYC  =
    (MIN_PULSE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DB_W           = 22;

  // Number of debounced carrier inputs and their positions
  localparam int unsigned NUM_IN         = 4;
  localparam int unsigned IN_RESET       = 0;
  localparam int unsigned IN_BUTTON      = 1;
  localparam int unsigned IN_SLEEP       = 2;
  localparam int unsigned IN_LID         = 3;

  // Reset values of the outputs
  localparam logic        RST_POWER_EN   = 1'b0;
  localparam logic        RST_STANDBY_N  = 1'b0;
  localparam logic        RST_RESET_N    = 1'b0;
  localparam logic [6:0]  RST_ALT_SEL    = 7'h7f;
  localparam int unsigned NUM_STRAP      = 8;
  localparam int unsigned NUM_MUX        = 7;

  // Boot sources, strap2/strap1/strap0 with ground as zero
  typedef enum logic [2:0] {
    MPB_BOOT_CARRIER_SATA = 3'b000,
    MPB_BOOT_CARRIER_SD   = 3'b001,
    MPB_BOOT_CARRIER_ESPI = 3'b010,
    MPB_BOOT_CARRIER_SPI  = 3'b011,
    MPB_BOOT_MODULE_NAND  = 3'b100,
    MPB_BOOT_REMOTE       = 3'b101,
    MPB_BOOT_MODULE_EMMC  = 3'b110,
    MPB_BOOT_MODULE_SPI   = 3'b111
  } mpb_boot_t;

  // Firmware location
  typedef enum logic {
    MPB_FW_MODULE  = 1'b0,
    MPB_FW_CARRIER = 1'b1
  } mpb_fw_t;

endpackage

/* tb/module_power_boot_manager_test.sv */
// Self-checking bench for the module power and boot manager
`timescale 1ns/10ps
module module_power_boot_manager_test;
  import mpb_pkg::*;

  // Short debounce window so held presses fit in the run
  localparam int unsigned TB_DB_CYC = 200;

  // One ordinary case: stimulus beside the outputs it should give
  typedef struct packed {
    logic [9:0] pull;
    logic       disk_n;
    logic       ram_n;
    logic [2:0] strap;
    logic [7:0] exp;
    logic       exp_fw;
  } mpb_row_t;

  logic       clk_sys, rst_n, disk_n, ram_n, mode_wr, saw, cpwr;
  logic [9:0] od_pull, od_pin;
  logic [2:0] strap_n;
  logic [7:0] strap_func, strap_wire, sp_out, sp_oe, strap_cfg;
  logic [6:0] mode_req, alt_sel;
  logic       pwr_en, stby_n, rst_out_n, sup_en, mrst, press, slp, lid;
  logic       bat, chg, chgr, tst, irq;
  mpb_boot_t  boot;
  mpb_fw_t    fw;
  int         error_cnt, cmp_count, i, n;
  logic [7:0] lv;
  mpb_row_t   rows [8];

  mpb_carrier_model carrier (
    .od_pull(od_pull), .od_pin(od_pin),
    .carrier_power_enable(pwr_en), .carrier_powered(cpwr),
    .strap_pins_out(sp_out), .strap_pins_oe(sp_oe),
    .strap_wire(strap_wire));

  mpb_manager #(.DB_CYC(TB_DB_CYC)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n),
    .supply_fault_n(od_pin[0]), .reset_request_n(od_pin[1]),
    .power_button_n(od_pin[2]), .sleep_request_n(od_pin[3]),
    .lid_closed_n(od_pin[4]), .battery_low_n(od_pin[5]),
    .charging_n(od_pin[6]), .charger_input_present_n(od_pin[7]),
    .test_request_n(od_pin[8]), .pm_bus_alert_n(od_pin[9]),
    .suspend_to_disk_state_n(disk_n), .suspend_to_ram_state_n(ram_n),
    .boot_source_strap0_n(strap_n[0]), .boot_source_strap1_n(strap_n[1]),
    .boot_source_strap2_n(strap_n[2]),
    .strap_pins_in(strap_wire), .strap_pins_func(strap_func),
    .strap_pins_out(sp_out), .strap_pins_oe(sp_oe),
    .gpio_mode_req(mode_req), .gpio_mode_write(mode_wr),
    .carrier_power_enable(pwr_en), .carrier_standby_n(stby_n),
    .reset_out_n(rst_out_n), .supply_enable(sup_en),
    .module_reset_req(mrst), .power_button_press(press),
    .sleep_request(slp), .lid_closed(lid), .battery_low(bat),
    .charging(chg), .charger_present(chgr), .test_mode(tst),
    .pm_bus_irq(irq), .boot_source(boot), .firmware_source(fw),
    .strap_config(strap_cfg), .alt_function_sel(alt_sel));

  // Free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Compare with case equality so unknowns never match
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic conclude;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hold reset, check held values, release, check strap capture
  task automatic do_reset(input int n);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (n) @(posedge clk_sys);
    #1;
    chk("rst_outs", {pwr_en, stby_n, rst_out_n, sup_en}, 0);
    chk("rst_oe", sp_oe, 0);
    chk("rst_boot", {boot, fw}, 4'he);
    chk("rst_alt", alt_sel, 7'h7f);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("strap_cfg", strap_cfg, 8'ha5);
    chk("strap_oe", sp_oe, 8'hff);
    chk("strap_out", sp_out, strap_func);
    chk("rst_out", rst_out_n, 1);
  endtask

  // One write pulse to the pin mode setting
  task automatic gpio_write(input logic [6:0] req);
    logic [6:0] inv;
    inv = ~req;
    @(posedge clk_sys);
    mode_req <= req;
    mode_wr <= 1'b1;
    @(posedge clk_sys);
    mode_wr <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("alt_sel", alt_sel, inv);
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    od_pull = '0;
    disk_n = 1'b1;
    ram_n = 1'b1;
    strap_n = 3'b111;
    strap_func = 8'h3c;
    mode_req = '0;
    mode_wr = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    saw = 1'b0;
    // Expected: power_en, standby_n, supply_en, bat, chg, chgr, test, irq
    rows[0] = '{10'h000, 1'b1, 1'b1, 3'b000, 8'he0, 1'b0};
    rows[1] = '{10'h001, 1'b1, 1'b1, 3'b001, 8'h40, 1'b0};
    rows[2] = '{10'h020, 1'b0, 1'b1, 3'b010, 8'h70, 1'b0};
    rows[3] = '{10'h0c0, 1'b1, 1'b0, 3'b011, 8'hac, 1'b1};
    rows[4] = '{10'h100, 1'b1, 1'b1, 3'b100, 8'he2, 1'b0};
    rows[5] = '{10'h200, 1'b0, 1'b0, 3'b101, 8'h21, 1'b0};
    rows[6] = '{10'h3e1, 1'b1, 1'b1, 3'b110, 8'h5f, 1'b0};
    rows[7] = '{10'h000, 1'b1, 1'b1, 3'b111, 8'he0, 1'b0};
    do_reset(12);
    for (i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      od_pull <= rows[i].pull;
      disk_n <= rows[i].disk_n;
      ram_n <= rows[i].ram_n;
      strap_n <= rows[i].strap;
      repeat (5) @(posedge clk_sys);
      #1;
      lv = {pwr_en, stby_n, sup_en, bat, chg, chgr, tst, irq};
      chk("levels", lv, rows[i].exp);
      chk("rail", cpwr, rows[i].exp[7]);
      chk("boot", boot, rows[i].strap);
      chk("fw", fw, rows[i].exp_fw);
    end
    // Pulses shorter than the debounce window must be ignored
    @(posedge clk_sys);
    od_pull <= 10'h01e;
    repeat (TB_DB_CYC - 20) begin
      @(posedge clk_sys);
      #1;
      saw = saw | press | mrst | slp | lid | ~rst_out_n;
    end
    @(posedge clk_sys);
    od_pull <= '0;
    repeat (10) @(posedge clk_sys);
    #1;
    saw = saw | press | mrst | slp | lid | ~rst_out_n;
    chk("short_pulse", saw, 0);
    // Held pulses are taken once the window has passed
    @(posedge clk_sys);
    od_pull <= 10'h01e;
    n = 0;
    while (!press && n < TB_DB_CYC + 50) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    // Two sync stages, the window, then one output stage
    chk("press_cyc", n, TB_DB_CYC + 3);
    chk("held", {mrst, slp, lid, rst_out_n}, 4'he);
    @(posedge clk_sys);
    #1;
    chk("press_once", press, 0);
    // Release also has to outlast the window
    @(posedge clk_sys);
    od_pull <= '0;
    repeat (TB_DB_CYC) @(posedge clk_sys);
    #1;
    chk("rel_early", {mrst, slp, lid}, 3'h7);
    repeat (5) @(posedge clk_sys);
    #1;
    chk("rel_done", {mrst, slp, lid, rst_out_n}, 4'h1);
    chk("rel_press", press, 0);
    gpio_write(7'h05);
    gpio_write(7'h7f);
    gpio_write(7'h12);
    // Second reset in mid-run must restore alternate functions
    do_reset(3);
    conclude();
  end

  // Watchdog against a hang
  initial begin
    repeat (100000) @(posedge clk_sys);
    error_cnt++;
    conclude();
  end
endmodule // module_power_boot_manager_test

/* tb/mpb_carrier_model.sv */
// Carrier board model: open-drain drivers, carrier rails, strap wires
`timescale 1ns/10ps
module mpb_carrier_model #(
  parameter logic [7:0] STRAP_PULL = 8'ha5
) (
  // Bench requests, one bit per open-drain line
  input  wire logic [9:0] od_pull,
  output logic      [9:0] od_pin,
  // Carrier rails gated by the module
  input  wire logic       carrier_power_enable,
  output logic            carrier_powered,
  // Strap pins as driven by the module
  input  wire logic [7:0] strap_pins_out,
  input  wire logic [7:0] strap_pins_oe,
  output logic      [7:0] strap_wire
);
  // Open-drain pull or float
  // A released line goes to the module pull-up, never to a held value
  assign od_pin = ~od_pull;

  assign carrier_powered = carrier_power_enable;

  // No carrier loads on straps
  // Undriven strap pins show only the module's own pull resistors
  assign strap_wire = (strap_pins_oe & strap_pins_out) |
                      (~strap_pins_oe & STRAP_PULL);
endmodule // mpb_carrier_model
